// >>> logic/dtc_pkg.sv
//==============================================================
package dtc_pkg;
  // Register word addresses (byte address = offset)
  localparam logic [7:0] ADDR_CTRL  = 8'h88;
  localparam logic [7:0] ADDR_MODE  = 8'h89;
  localparam logic [7:0] ADDR_TL0   = 8'h8A;
  localparam logic [7:0] ADDR_TL1   = 8'h8B;
  localparam logic [7:0] ADDR_TH0   = 8'h8C;
  localparam logic [7:0] ADDR_TH1   = 8'h8D;
  localparam logic [7:0] ADDR_AMODE = 8'h8F;
  localparam logic [7:0] ADDR_AUX   = 8'hA2;
  // Reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h00;
  // Control register bit positions
  localparam int B_IT0 = 0;
  localparam int B_IE0 = 1;
  localparam int B_IT1 = 2;
  localparam int B_IE1 = 3;
  localparam int B_TR0 = 4;
  localparam int B_TF0 = 5;
  localparam int B_TR1 = 6;
  localparam int B_TF1 = 7;
  // Mode register bit positions, timer one is shifted by four
  localparam int B_GATE = 3;
  localparam int B_CT   = 2;
  localparam int T1_SHIFT = 4;
  // Auxiliary: toggle enables
  localparam int B_TOGGLE_ENABLE_ZERO = 0;
  localparam int B_TOGGLE_ENABLE_ONE = 1;
  // Mode field codes
  typedef enum logic [2:0] {
    DTC_M0  = 3'b000,
    DTC_M1  = 3'b001,
    DTC_M2  = 3'b010,
    DTC_M3  = 3'b011,
    DTC_PWM = 3'b110
  } dtc_mode_t;
  // Slave answers one cycle after the request appears
  localparam int WAIT_CYCLES = 1;
endpackage : dtc_pkg

// >>> logic/dtc_timers.sv
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps
module dtc_timers (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  // Avalon-MM slave
  input  wire logic [7:0] AVS_ADDRESS,
  input  wire logic       AVS_READ,
  input  wire logic       AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0]     AVS_READDATA,
  output logic            AVS_WAITREQUEST,
  output logic [1:0]      AVS_RESPONSE,
  // Interrupt controller acknowledges (one-cycle pulses)
  input  wire logic       ACK_TIMER0,
  input  wire logic       ACK_TIMER1,
  input  wire logic       ACK_EXT0,
  input  wire logic       ACK_EXT1,
  // Pins
  input  wire logic       EXT_GATE_INPUT0_N,
  input  wire logic       EXT_GATE_INPUT1_N,
  input  wire logic       COUNT_PIN0_IN,
  input  wire logic       COUNT_PIN1_IN,
  output logic            COUNT_PIN0_OUT,
  output logic            COUNT_PIN1_OUT,
  output logic            COUNT_PIN0_OE,
  output logic            COUNT_PIN1_OE,
  // Flag outputs to interrupt logic
  output logic [3:0]      IRQ_FLAGS,
  // Timer one overflow pulse for the baud generator
  output logic            BAUD_TICK
);

  //==============================================================
  // Registers
  logic [7:0] ctrl_reg;
  logic [7:0] mode_reg;
  logic [1:0] mode2_reg;     // High mode bits of both timers
  logic [1:0] aux_reg;       // Toggle enables
  logic [7:0] tl_reg [2];
  logic [7:0] th_reg [2];
  logic [1:0] tog_reg;
  logic       bus_done_reg;

  //==============================================================
  // Pin synchronisers: levels read from the second stage, edges from the second and third
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
      sync3_reg <= 4'hF;
    end else begin
      sync1_reg <= {EXT_GATE_INPUT1_N, EXT_GATE_INPUT0_N, COUNT_PIN1_IN, COUNT_PIN0_IN};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  // Falling transitions, after synchronising
  logic [3:0] fall;
  assign fall = sync3_reg & ~sync2_reg;

  //==============================================================
  // Mode decoding
  function automatic logic [2:0] mode_of(input int n);
    mode_of = (n == 0) ? {mode2_reg[0], mode_reg[1:0]} : {mode2_reg[1], mode_reg[5:4]};
  endfunction
  logic [2:0] m0;
  logic [2:0] m1;
  assign m0 = mode_of(0);
  assign m1 = mode_of(1);

  logic [1:0] enable;
  logic [1:0] pulse;
  always_comb begin
    enable[0] = ctrl_reg[dtc_pkg::B_TR0] &
                (!mode_reg[dtc_pkg::B_GATE] | sync2_reg[2]);
    // timer one stopped in mode three
    enable[1] = ctrl_reg[dtc_pkg::B_TR1] & (m1 != dtc_pkg::DTC_M3) &
                (!mode_reg[dtc_pkg::B_GATE + dtc_pkg::T1_SHIFT] | sync2_reg[3]);
    // CPU clock or pin pulses; falling edge counting
    pulse[0] = enable[0] & (mode_reg[dtc_pkg::B_CT] ? fall[0] : 1'b1);
    pulse[1] = enable[1] &
               (mode_reg[dtc_pkg::B_CT + dtc_pkg::T1_SHIFT] ? fall[1] : 1'b1);
  end
  // high byte of timer zero in mode three runs on timer one run bit
  logic split_pulse;
  assign split_pulse = (m0 == dtc_pkg::DTC_M3) & ctrl_reg[dtc_pkg::B_TR1];

  //==============================================================
  // Next-count logic for each timer
  logic [7:0] tl_next [2];
  logic [7:0] th_next [2];
  logic [1:0] ovf;
  logic [1:0] pwm_hi;       // Flag level in PWM mode
  logic       split_ovf;
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      tl_next[n] = tl_reg[n];
      th_next[n] = th_reg[n];
      ovf[n]     = 1'b0;
      pwm_hi[n]  = 1'b0;
    end
    split_ovf = 1'b0;
    for (int n = 0; n < 2; n++) begin
      unique case (mode_of(n))
        dtc_pkg::DTC_M0: if (pulse[n]) begin
          tl_next[n] = {tl_reg[n][7:5], tl_reg[n][4:0] + 5'h01};
          if (tl_reg[n][4:0] == 5'h1F) begin
            th_next[n] = th_reg[n] + 8'h01;
            ovf[n] = (th_reg[n] == 8'hFF);
          end
        end
        dtc_pkg::DTC_M1: if (pulse[n]) begin
          {th_next[n], tl_next[n]} = {th_reg[n], tl_reg[n]} + 16'h0001;
          ovf[n] = ({th_reg[n], tl_reg[n]} == 16'hFFFF);
        end
        dtc_pkg::DTC_M2: if (pulse[n]) begin
          tl_next[n] = (tl_reg[n] == 8'hFF) ? th_reg[n] : tl_reg[n] + 8'h01;
          ovf[n] = (tl_reg[n] == 8'hFF);
        end
        dtc_pkg::DTC_M3: if (n == 0) begin
          if (pulse[0]) begin
            tl_next[0] = tl_reg[0] + 8'h01;
            ovf[0] = (tl_reg[0] == 8'hFF);
          end
          if (split_pulse) begin
            th_next[0] = th_reg[0] + 8'h01;
            split_ovf = (th_reg[0] == 8'hFF);
          end
        end
        dtc_pkg::DTC_PWM: begin
          if (pulse[n]) begin
            tl_next[n] = tl_reg[n] + 8'h01;
            ovf[n] = (tl_reg[n] == 8'hFF);
          end
          // low for high-byte clocks, high for the remainder
          pwm_hi[n] = (tl_reg[n] >= th_reg[n]);
        end
        default: ;  // Reserved codes hold the count
      endcase
    end
  end

  //==============================================================
  // Bus decode
  logic       req;
  logic       wr_ok;
  logic       mapped;
  logic [7:0] wdat;
  assign req   = (AVS_READ | AVS_WRITE) & !bus_done_reg;
  assign wdat  = AVS_WRITEDATA[7:0];
  assign wr_ok = req & AVS_WRITE & AVS_BYTEENABLE[0];
  always_comb begin
    unique case (AVS_ADDRESS)
      dtc_pkg::ADDR_CTRL, dtc_pkg::ADDR_MODE, dtc_pkg::ADDR_TL0,
      dtc_pkg::ADDR_TL1, dtc_pkg::ADDR_TH0, dtc_pkg::ADDR_TH1,
      dtc_pkg::ADDR_AMODE, dtc_pkg::ADDR_AUX: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  function automatic logic wr_at(input logic [7:0] a);
    wr_at = wr_ok & (AVS_ADDRESS == a);
  endfunction

  // Waitrequest low for one cycle after request seen
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bus_done_reg    <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
      AVS_RESPONSE    <= 2'b00;
    end else begin
      bus_done_reg    <= req;
      AVS_WAITREQUEST <= !req;
      AVS_RESPONSE    <= (req && !mapped) ? 2'b10 : 2'b00;
      if (req && AVS_READ) begin
        unique case (AVS_ADDRESS)
          dtc_pkg::ADDR_CTRL:  AVS_READDATA <= {24'h0, ctrl_reg};
          dtc_pkg::ADDR_MODE:  AVS_READDATA <= {24'h0, mode_reg};
          dtc_pkg::ADDR_TL0:   AVS_READDATA <= {24'h0, tl_reg[0]};
          dtc_pkg::ADDR_TL1:   AVS_READDATA <= {24'h0, tl_reg[1]};
          dtc_pkg::ADDR_TH0:   AVS_READDATA <= {24'h0, th_reg[0]};
          dtc_pkg::ADDR_TH1:   AVS_READDATA <= {24'h0, th_reg[1]};
          dtc_pkg::ADDR_AMODE: AVS_READDATA <= {27'h0, mode2_reg[1], 3'h0, mode2_reg[0]};
          dtc_pkg::ADDR_AUX:   AVS_READDATA <= {30'h0, aux_reg};
          default:             AVS_READDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  //==============================================================
  // Mode and auxiliary registers; reserved codes simply hold
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mode_reg  <= dtc_pkg::MODE_RST;
      mode2_reg <= 2'b00;
      aux_reg   <= 2'b00;
    end else begin
      if (wr_at(dtc_pkg::ADDR_MODE))  mode_reg  <= wdat;
      if (wr_at(dtc_pkg::ADDR_AMODE)) mode2_reg <= {wdat[4], wdat[0]};
      if (wr_at(dtc_pkg::ADDR_AUX))   aux_reg   <= wdat[1:0];
    end
  end

  // count bytes change only by counting or direct write
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tl_reg[0] <= 8'h00;
      tl_reg[1] <= 8'h00;
      th_reg[0] <= 8'h00;
      th_reg[1] <= 8'h00;
    end else begin
      tl_reg[0] <= wr_at(dtc_pkg::ADDR_TL0) ? wdat : tl_next[0];
      tl_reg[1] <= wr_at(dtc_pkg::ADDR_TL1) ? wdat : tl_next[1];
      th_reg[0] <= wr_at(dtc_pkg::ADDR_TH0) ? wdat : th_next[0];
      th_reg[1] <= wr_at(dtc_pkg::ADDR_TH1) ? wdat : th_next[1];
    end
  end

  //==============================================================
  // Control register with hardware flags; set wins over clear
  logic [1:0] tf_set;
  logic [1:0] tf_clr;
  logic [1:0] ie_set;
  logic       wr_ctrl;
  logic [1:0] pwm_rise;
  logic [1:0] pwm_hi_reg;
  assign wr_ctrl = wr_at(dtc_pkg::ADDR_CTRL);
  // falling edge when type bit set, low level otherwise
  assign ie_set[0] = ctrl_reg[dtc_pkg::B_IT0] ? fall[2] : !sync2_reg[2];
  assign ie_set[1] = ctrl_reg[dtc_pkg::B_IT1] ? fall[3] : !sync2_reg[3];
  always_comb begin
    pwm_rise = pwm_hi & ~pwm_hi_reg;
    // timer one outside mode three sets no flag while timer zero split
    tf_set[0] = ovf[0];
    tf_set[1] = (m0 == dtc_pkg::DTC_M3) ? split_ovf : ovf[1];
    tf_clr[0] = ACK_TIMER0;
    tf_clr[1] = ACK_TIMER1;
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_reg   <= dtc_pkg::CTRL_RST;
      pwm_hi_reg <= 2'b00;
    end else begin
      pwm_hi_reg <= pwm_hi;
      // run and type bits written by software
      if (wr_ctrl) begin
        ctrl_reg[dtc_pkg::B_IT0] <= wdat[dtc_pkg::B_IT0];
        ctrl_reg[dtc_pkg::B_IT1] <= wdat[dtc_pkg::B_IT1];
        ctrl_reg[dtc_pkg::B_TR0] <= wdat[dtc_pkg::B_TR0];
        ctrl_reg[dtc_pkg::B_TR1] <= wdat[dtc_pkg::B_TR1];
      end
      ctrl_reg[dtc_pkg::B_IE0] <= ie_set[0] | (ctrl_reg[dtc_pkg::B_IE0] & !ACK_EXT0 &
                                  !(wr_ctrl & !wdat[dtc_pkg::B_IE0]));
      ctrl_reg[dtc_pkg::B_IE1] <= ie_set[1] | (ctrl_reg[dtc_pkg::B_IE1] & !ACK_EXT1 &
                                  !(wr_ctrl & !wdat[dtc_pkg::B_IE1]));
      // PWM flag follows rising edge; software clear honoured
      if (m0 == dtc_pkg::DTC_PWM)
        ctrl_reg[dtc_pkg::B_TF0] <= pwm_rise[0] | (pwm_hi[0] & ctrl_reg[dtc_pkg::B_TF0] &
                                    !(wr_ctrl & !wdat[dtc_pkg::B_TF0]));
      else
        ctrl_reg[dtc_pkg::B_TF0] <= tf_set[0] | (ctrl_reg[dtc_pkg::B_TF0] & !tf_clr[0] &
                                    !(wr_ctrl & !wdat[dtc_pkg::B_TF0]));
      if (m1 == dtc_pkg::DTC_PWM && m0 != dtc_pkg::DTC_M3)
        ctrl_reg[dtc_pkg::B_TF1] <= pwm_rise[1] | (pwm_hi[1] & ctrl_reg[dtc_pkg::B_TF1] &
                                    !(wr_ctrl & !wdat[dtc_pkg::B_TF1]));
      else
        ctrl_reg[dtc_pkg::B_TF1] <= tf_set[1] | (ctrl_reg[dtc_pkg::B_TF1] & !tf_clr[1] &
                                    !(wr_ctrl & !wdat[dtc_pkg::B_TF1]));
    end
  end

  //==============================================================
  // Pin outputs: PWM level or toggle; leaves clock source to software
  logic [1:0] ten_prev_reg;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          tog_reg[g]      <= 1'b1;
          ten_prev_reg[g] <= 1'b0;
        end else begin
          ten_prev_reg[g] <= aux_reg[g];
          if (aux_reg[g] && !ten_prev_reg[g])
            tog_reg[g] <= 1'b1;
          else if (aux_reg[g] && ovf[g])
            tog_reg[g] <= !tog_reg[g];
        end
      end
    end
  endgenerate

  // Drive pins; forced levels at 00h and FFh
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      COUNT_PIN0_OUT <= 1'b1;
      COUNT_PIN1_OUT <= 1'b1;
      COUNT_PIN0_OE  <= 1'b0;
      COUNT_PIN1_OE  <= 1'b0;
      IRQ_FLAGS      <= 4'h0;
      BAUD_TICK      <= 1'b0;
    end else begin
      COUNT_PIN0_OE  <= (m0 == dtc_pkg::DTC_PWM) | aux_reg[0];
      COUNT_PIN1_OE  <= (m1 == dtc_pkg::DTC_PWM) | aux_reg[1];
      COUNT_PIN0_OUT <= (m0 != dtc_pkg::DTC_PWM) ? tog_reg[0] :
                        (th_reg[0] == 8'h00) ? 1'b1 :
                        (th_reg[0] == 8'hFF) ? 1'b0 : pwm_hi[0];
      COUNT_PIN1_OUT <= (m1 != dtc_pkg::DTC_PWM) ? tog_reg[1] :
                        (th_reg[1] == 8'h00) ? 1'b1 :
                        (th_reg[1] == 8'hFF) ? 1'b0 : pwm_hi[1];
      IRQ_FLAGS      <= {ctrl_reg[dtc_pkg::B_TF1], ctrl_reg[dtc_pkg::B_IE1],
                         ctrl_reg[dtc_pkg::B_TF0], ctrl_reg[dtc_pkg::B_IE0]};
      BAUD_TICK      <= ovf[1];
    end
  end

  //==============================================================
  // Assertions
  a_mode1_wrap:
  assert property (@(posedge CLK) disable iff (!RST_N)
    (m0 == dtc_pkg::DTC_M1 && pulse[0] && {th_reg[0], tl_reg[0]} == 16'hFFFF
     && !wr_ok) |=> ctrl_reg[dtc_pkg::B_TF0] && tl_reg[0] == 8'h00)
    else $error("mode one wrap missed");
  a_reload_low:
  assert property (@(posedge CLK) disable iff (!RST_N)
    (m0 == dtc_pkg::DTC_M2 && pulse[0] && tl_reg[0] == 8'hFF && !wr_ok)
    |=> tl_reg[0] == $past(th_reg[0]))
    else $error("reload wrong");
  a_run_hold:
  assert property (@(posedge CLK) disable iff (!RST_N)
    (!ctrl_reg[dtc_pkg::B_TR0] && !wr_ok) |=> $stable(tl_reg[0]))
    else $error("count moved while stopped");
  a_t1_stop:
  assert property (@(posedge CLK) disable iff (!RST_N)
    (m1 == dtc_pkg::DTC_M3 && !wr_ok) |=> $stable(tl_reg[1]) && $stable(th_reg[1]))
    else $error("timer one ran in mode three");
  a_force_high:
  assert property (@(posedge CLK) disable iff (!RST_N)
    (m0 == dtc_pkg::DTC_PWM && th_reg[0] == 8'h00) |=> COUNT_PIN0_OUT)
    else $error("pin not forced high");
  a_edge_flag:
  assert property (@(posedge CLK) disable iff (!RST_N)
    (ctrl_reg[dtc_pkg::B_IT0] && fall[2]) |=> ctrl_reg[dtc_pkg::B_IE0])
    else $error("edge flag missed");
  a_toggle_start:
  assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(aux_reg[0]) |=> tog_reg[0])
    else $error("toggle not started high");
  a_bus_answer:
  assert property (@(posedge CLK) disable iff (!RST_N)
    req |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer timing");

endmodule : dtc_timers

// >>> tb/dtc_core_model.sv
`timescale 1ns/10ps
//==============================================================
// Core side model: register bus master
module dtc_core_model (
  // Clock
  input  wire logic        clk,
  // Slave answer
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  input  wire logic [1:0]  response,
  // Request
  output logic [7:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata,
  output logic [3:0]       byteenable
);
  logic [31:0] rdata;
  logic [1:0]  rresp;

  // Idle bus from time zero
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'hF;
  end

  // Held until waitrequest is seen low; only the bench timeout ends a stuck wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h000000, d};
    write <= w;
    read <= ~w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rdata = readdata;
    rresp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule // dtc_core_model

// >>> tb/test_dual_timer_counter_modes.sv
`timescale 1ns/10ps
//==============================================================
// Bench top
module test_dual_timer_counter_modes;
  logic        clk, rst_n, rd, wr, wreq, ack0, ack1, acke0, acke1;
  logic        gate0_n, gate1_n, cin0, cin1, out0, oe0, out1, oe1, tick;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [3:0]  be, flags;
  logic [1:0]  resp;
  int          error_cnt, samples_checked;

  dtc_core_model core (.clk(clk), .waitrequest(wreq), .readdata(rdat), .response(resp),
    .address(adr), .read(rd), .write(wr), .writedata(wdat), .byteenable(be));

  dtc_timers dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .AVS_RESPONSE(resp), .ACK_TIMER0(ack0), .ACK_TIMER1(ack1),
    .ACK_EXT0(acke0), .ACK_EXT1(acke1), .EXT_GATE_INPUT0_N(gate0_n),
    .EXT_GATE_INPUT1_N(gate1_n), .COUNT_PIN0_IN(cin0), .COUNT_PIN1_IN(cin1),
    .COUNT_PIN0_OUT(out0), .COUNT_PIN1_OUT(out1), .COUNT_PIN0_OE(oe0), .COUNT_PIN1_OE(oe1),
    .IRQ_FLAGS(flags), .BAUD_TICK(tick));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    core.xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    core.xfer(1'b0, a, 8'h00);
    chk(core.rdata, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait on a flag, sampled away from the edge
  task automatic wait_flag(input int i);
    int n;
    n = 0;
    while (flags[i] !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(flags[i], 1'b1);
  endtask

  // One-cycle acknowledge: 0 for timer zero, 1 for external interrupt zero
  task automatic pulse(input int i);
    @(posedge clk);
    if (i == 0) ack0 <= 1'b1;
    else acke0 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    acke0 <= 1'b0;
    @(negedge clk);
  endtask

  task automatic t_reset;
    rdc(dtc_pkg::ADDR_CTRL, dtc_pkg::CTRL_RST);
    rdc(dtc_pkg::ADDR_MODE, dtc_pkg::MODE_RST);
    // Unmapped place answers with an error code
    core.xfer(1'b0, 8'h90, 8'h00);
    chk(core.rresp, 2'b10);
    $display("reset test done");
  endtask

  task automatic t_gate;
    wrr(dtc_pkg::ADDR_MODE, 8'h08);
    wrr(dtc_pkg::ADDR_TL0, 8'h10);
    wrr(dtc_pkg::ADDR_TH0, 8'h20);
    gate0_n <= 1'b0;
    wrr(dtc_pkg::ADDR_CTRL, 8'h10);
    rdc(dtc_pkg::ADDR_TL0, 8'h10);
    rdc(dtc_pkg::ADDR_TH0, 8'h20);
    idle(20);
    rdc(dtc_pkg::ADDR_TL0, 8'h10);
    gate0_n <= 1'b1;
    idle(6);
    core.xfer(1'b0, dtc_pkg::ADDR_TL0, 8'h00);
    chk(core.rdata[4:0] > 5'h10 && core.rdata[4:0] < 5'h18, 1'b1);
    wrr(dtc_pkg::ADDR_CTRL, 8'h00);
    $display("gate test done");
  endtask

  task automatic t_mode0;
    wrr(dtc_pkg::ADDR_MODE, 8'h00);
    wrr(dtc_pkg::ADDR_TH0, 8'hFF);
    wrr(dtc_pkg::ADDR_TL0, 8'h1F);
    wrr(dtc_pkg::ADDR_CTRL, 8'h10);
    wait_flag(1);
    wrr(dtc_pkg::ADDR_CTRL, 8'h00);
    rdc(dtc_pkg::ADDR_TH0, 8'h00);
    $display("mode zero test done");
  endtask

  task automatic t_mode1;
    wrr(dtc_pkg::ADDR_TH0, 8'hFF);
    wrr(dtc_pkg::ADDR_TL0, 8'hFE);
    // Internal clock selected so the toggle output works
    // select bit clear
    wrr(dtc_pkg::ADDR_MODE, 8'h01);
    wrr(dtc_pkg::ADDR_AUX, 8'h01);
    @(negedge clk);
    chk(out0, 1'b1);
    chk(oe0, 1'b1);
    wrr(dtc_pkg::ADDR_CTRL, 8'h10);
    wait_flag(1);
    @(negedge clk);
    chk(out0, 1'b0);
    pulse(0);
    // Flag outputs trail the control register by one cycle
    @(negedge clk);
    chk(flags[1], 1'b0);
    wrr(dtc_pkg::ADDR_CTRL, 8'h00);
    rdc(dtc_pkg::ADDR_TH0, 8'h00);
    wrr(dtc_pkg::ADDR_AUX, 8'h00);
    $display("mode one test done");
  endtask

  task automatic t_mode2;
    wrr(dtc_pkg::ADDR_MODE, 8'h02);
    wrr(dtc_pkg::ADDR_TH0, 8'hF0);
    wrr(dtc_pkg::ADDR_TL0, 8'hFE);
    wrr(dtc_pkg::ADDR_CTRL, 8'h10);
    wait_flag(1);
    wrr(dtc_pkg::ADDR_CTRL, 8'h00);
    rdc(dtc_pkg::ADDR_TH0, 8'hF0);
    core.xfer(1'b0, dtc_pkg::ADDR_TL0, 8'h00);
    chk(core.rdata[7:4], 4'hF);
    $display("mode two test done");
  endtask

  task automatic t_split;
    wrr(dtc_pkg::ADDR_TL0, 8'hFE);
    wrr(dtc_pkg::ADDR_TH0, 8'hFE);
    wrr(dtc_pkg::ADDR_MODE, 8'h03);
    wrr(dtc_pkg::ADDR_CTRL, 8'h40);
    wait_flag(3);
    wrr(dtc_pkg::ADDR_CTRL, 8'h00);
    rdc(dtc_pkg::ADDR_TL0, 8'hFE);
    // Timer one kept running outside its own mode three
    core.xfer(1'b0, dtc_pkg::ADDR_TL1, 8'h00);
    chk(core.rdata[7:0] != 8'h00, 1'b1);
    wrr(dtc_pkg::ADDR_MODE, 8'h30);
    wrr(dtc_pkg::ADDR_TL1, 8'h55);
    wrr(dtc_pkg::ADDR_CTRL, 8'h40);
    idle(20);
    rdc(dtc_pkg::ADDR_TL1, 8'h55);
    wrr(dtc_pkg::ADDR_CTRL, 8'h00);
    $display("split mode test done");
  endtask

  task automatic t_pwm;
    int n;
    wrr(dtc_pkg::ADDR_MODE, 8'h02);
    wrr(dtc_pkg::ADDR_AMODE, 8'h01);
    wrr(dtc_pkg::ADDR_TH0, 8'h00);
    wrr(dtc_pkg::ADDR_CTRL, 8'h10);
    idle(3);
    for (int i = 0; i < 300; i += 100) begin
      @(negedge clk);
      chk(out0, 1'b1);
      idle(100);
    end
    wrr(dtc_pkg::ADDR_TH0, 8'hFF);
    idle(3);
    for (int i = 0; i < 300; i += 100) begin
      @(negedge clk);
      chk(out0, 1'b0);
      idle(100);
    end
    // Low phase within the range software must keep to
    // high byte in range
    wrr(dtc_pkg::ADDR_TH0, 8'h40);
    idle(300);
    n = 0;
    repeat (256) begin
      @(negedge clk);
      if (flags[1] === 1'b0) n++;
    end
    chk(n, 64);
    wrr(dtc_pkg::ADDR_CTRL, 8'h00);
    wrr(dtc_pkg::ADDR_AMODE, 8'h00);
    $display("pwm test done");
  endtask

  task automatic t_ext;
    wrr(dtc_pkg::ADDR_CTRL, 8'h01);
    gate0_n <= 1'b0;
    wait_flag(0);
    pulse(1);
    idle(4);
    chk(flags[0], 1'b0);
    gate0_n <= 1'b1;
    wrr(dtc_pkg::ADDR_CTRL, 8'h00);
    gate0_n <= 1'b0;
    wait_flag(0);
    idle(1);
    gate0_n <= 1'b1;
    idle(5);
    wrr(dtc_pkg::ADDR_CTRL, 8'h00);
    @(negedge clk);
    chk(flags[0], 1'b0);
    $display("external irq test done");
  endtask

  task automatic t_count;
    wrr(dtc_pkg::ADDR_MODE, 8'h05);
    wrr(dtc_pkg::ADDR_TL0, 8'h00);
    wrr(dtc_pkg::ADDR_TH0, 8'h00);
    wrr(dtc_pkg::ADDR_CTRL, 8'h10);
    repeat (3) begin
      cin0 <= 1'b0;
      idle(4);
      cin0 <= 1'b1;
      idle(4);
    end
    idle(4);
    wrr(dtc_pkg::ADDR_CTRL, 8'h00);
    rdc(dtc_pkg::ADDR_TL0, 8'h03);
    $display("counter test done");
  endtask

  // Timer one auto-reload with toggle pin and baud tick
  task automatic t_timer1;
    logic o;
    int   n;
    wrr(dtc_pkg::ADDR_MODE, 8'h20);
    wrr(dtc_pkg::ADDR_TH1, 8'hFC);
    wrr(dtc_pkg::ADDR_TL1, 8'hFE);
    // select bit clear for the toggle pin
    wrr(dtc_pkg::ADDR_AUX, 8'h02);
    @(negedge clk);
    chk(out1, 1'b1);
    chk(oe1, 1'b1);
    wrr(dtc_pkg::ADDR_CTRL, 8'h40);
    wait_flag(3);
    // Reload from FCh gives one overflow every four clocks
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (tick === 1'b1) n++;
    end
    chk(n, 10);
    o = out1;
    repeat (4) @(negedge clk);
    chk(out1, !o);
    wrr(dtc_pkg::ADDR_CTRL, 8'h00);
    wrr(dtc_pkg::ADDR_AUX, 8'h00);
    rdc(dtc_pkg::ADDR_TH1, 8'hFC);
    $display("timer one test done");
  endtask

  // Main sequence
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    clk = 1'b0;
    rst_n = 1'b0;
    {ack0, ack1, acke0, acke1} = 4'h0;
    {gate0_n, gate1_n, cin0, cin1} = 4'hF;
    idle(3);
    rst_n <= 1'b1;
    t_reset;
    t_gate;
    t_mode0;
    t_mode1;
    t_mode2;
    t_split;
    t_pwm;
    t_ext;
    t_count;
    t_timer1;
    end_sim;
  end

  // Watchdog, well beyond the roughly 1500 cycles the tests need
  initial begin
    idle(20000);
    error_cnt++;
    end_sim;
  end
endmodule // test_dual_timer_counter_modes
